// [inc/trig_seq_params.svh]
// constants for the state trigger sequencer and its register map
// Contract
// - each matched term arms only the next
// - trigger only after all terms in order
// - find term plus three levels, select a
// - final term fires on programmed occurrence count
// - eventual link accepts any later state
// - immediate link misses fall back to find
// - start mode stores trigger state first
// - center/end modes keep all sequence states
// - immediate final term ignores occurrence count
// - final term ORs extra resource terms
// - restart term returns search to find
// - restart is OR of selectable terms
// - no restart term keeps partial progress
// - center mode stores 512 more, stops
// - end mode stops at trigger state
`ifndef TRIG_SEQ_PARAMS_SVH
`define TRIG_SEQ_PARAMS_SVH

`define ADDR_CTRL 3'h0
`define ADDR_SEL 3'h1
`define ADDR_LINK 3'h2
`define ADDR_OR_MASK 3'h3
`define ADDR_RS_MASK 3'h4
`define ADDR_OCC 3'h5
`define ADDR_STATUS 3'h6
`define ADDR_OCC_CNT 3'h7

`define CTRL_START_BIT 0
`define CTRL_POS_LSB 1
`define CTRL_POS_MSB 2
`define CTRL_LAST_LSB 3
`define CTRL_LAST_MSB 4

`define POS_START 2'h0
`define POS_CENTER 2'h1
`define POS_END 2'h2

`define POS_RST 2'h0
`define LAST_RST 2'h0
`define SEL_RST 12'h000
`define LINK_RST 4'h0
`define MASK_RST 8'h00
`define OCC_RST 16'h0001

`define POST_CENTER 16'h0200
`define POST_END 16'h0000
`define MEM_DEPTH_DEF 16'h0400

`endif

// [inc/trig_seq_pkg.sv]
// types shared by the trigger sequencer files
package trig_seq_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] match;
  } sample_t;

  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] last_level;
    logic [11:0] sel;
    logic [3:0] imm;
    logic [7:0] or_mask;
    logic [7:0] rs_mask;
    logic [15:0] occ;
  } seq_cfg_t;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_PRE,
    CAP_POST,
    CAP_DONE
  } cap_state_t;

endpackage

// [design/term_select.sv]
// per-level resource term selection
module term_select #(
  parameter int LEVELS = 4,
  parameter int TERMS = 8,
  parameter int SEL_W = 3
) (
  input wire logic [TERMS-1:0] match,
  input wire logic [LEVELS*SEL_W-1:0] sel,
  output logic [LEVELS-1:0] hit
);

  genvar i;
  generate
    for (i = 0; i < LEVELS; i++) begin : g_lvl
      // selector value 0 picks resource term a
      assign hit[i] = match[sel[i*SEL_W +: SEL_W]];
    end
  endgenerate

endmodule // term_select

// [design/capture_ctl.sv]
// store enable and stop control around the trigger position
`include "trig_seq_params.svh"

module capture_ctl #(
  parameter logic [15:0] MEM_DEPTH = `MEM_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic sample_valid,
  input wire logic trig_now,
  input wire logic [1:0] pos,
  output logic store_en,
  output logic done,
  output logic active
);

  trig_seq_pkg::cap_state_t state_reg;
  trig_seq_pkg::cap_state_t state_next;
  logic [15:0] post_reg;
  logic [15:0] post_next;
  logic store_next;
  logic [15:0] post_len;

  always_comb begin
    case (pos)
      `POS_CENTER: post_len = `POST_CENTER;
      `POS_END: post_len = `POST_END;
      default: post_len = MEM_DEPTH - 16'h0001;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    post_next = post_reg;
    store_next = 1'b0;
    if (start) begin
      state_next = trig_seq_pkg::CAP_PRE;
      post_next = 16'h0000;
    end else if (sample_valid) begin
      case (state_reg)
        trig_seq_pkg::CAP_PRE: begin
          // start mode stores nothing ahead of the trigger
          store_next = trig_now || (pos != `POS_START);
          if (trig_now) begin
            post_next = post_len;
            if (post_len == 16'h0000) begin
              state_next = trig_seq_pkg::CAP_DONE;
            end else begin
              state_next = trig_seq_pkg::CAP_POST;
            end
          end
        end
        trig_seq_pkg::CAP_POST: begin
          store_next = 1'b1;
          post_next = post_reg - 16'h0001;
          if (post_reg == 16'h0001) begin
            state_next = trig_seq_pkg::CAP_DONE;
          end
        end
        default: begin
          store_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= trig_seq_pkg::CAP_IDLE;
      post_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      post_reg <= post_next;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      store_en <= 1'b0;
      done <= 1'b0;
      active <= 1'b0;
    end else begin
      store_en <= store_next;
      done <= (state_next == trig_seq_pkg::CAP_DONE);
      active <= (state_next == trig_seq_pkg::CAP_PRE) ||
                (state_next == trig_seq_pkg::CAP_POST);
    end
  end

endmodule // capture_ctl

// [design/state_trigger_sequencer.sv]
// trigger sequencer top: registers, sequence walk, capture control
`include "trig_seq_params.svh"

module state_trigger_sequencer #(
  parameter logic [15:0] MEM_DEPTH = `MEM_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire trig_seq_pkg::sample_t smp,
  output logic trigger,
  output logic store_en,
  output logic acq_done
);

  localparam int LEVELS = 4;

  trig_seq_pkg::seq_cfg_t cfg;
  logic [1:0] pos_reg;
  logic [1:0] last_reg;
  logic [11:0] sel_reg;
  logic [3:0] imm_reg;
  logic [7:0] or_mask_reg;
  logic [7:0] rs_mask_reg;
  logic [15:0] occ_reg;
  logic start_reg;

  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic [15:0] occ_cnt_reg;
  logic [15:0] occ_cnt_next;
  logic armed_reg;
  logic trig_now;
  logic [LEVELS-1:0] hit;
  logic final_hit;
  logic rs_hit;
  logic imm_final;
  logic [16:0] occ_plus;
  logic cap_store;
  logic cap_done;
  logic cap_active;

  // level index following a fallback: the failing state may itself be a find
  function automatic logic [1:0] restart_level(input logic find_hit);
    restart_level = find_hit ? 2'h1 : 2'h0;
  endfunction

  assign cfg.pos = pos_reg;
  assign cfg.last_level = last_reg;
  assign cfg.sel = sel_reg;
  assign cfg.imm = {imm_reg[3:1], 1'b0};
  assign cfg.or_mask = or_mask_reg;
  assign cfg.rs_mask = rs_mask_reg;
  assign cfg.occ = occ_reg;

  // configuration writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_reg <= `POS_RST;
      last_reg <= `LAST_RST;
      sel_reg <= `SEL_RST;
      imm_reg <= `LINK_RST;
      or_mask_reg <= `MASK_RST;
      rs_mask_reg <= `MASK_RST;
      occ_reg <= `OCC_RST;
    end else if (wr_en) begin
      case (addr)
        `ADDR_CTRL: begin
          pos_reg <= wr_data[`CTRL_POS_MSB:`CTRL_POS_LSB];
          last_reg <= wr_data[`CTRL_LAST_MSB:`CTRL_LAST_LSB];
        end
        `ADDR_SEL: sel_reg <= wr_data[11:0];
        `ADDR_LINK: imm_reg <= {wr_data[3:1], 1'b0};
        `ADDR_OR_MASK: or_mask_reg <= wr_data[7:0];
        `ADDR_RS_MASK: rs_mask_reg <= wr_data[7:0];
        `ADDR_OCC: occ_reg <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // run start pulse, taken from the control write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_en && (addr == `ADDR_CTRL) &&
                   wr_data[`CTRL_START_BIT];
    end
  end

  term_select #(
    .LEVELS(LEVELS),
    .TERMS(8),
    .SEL_W(3)
  ) u_sel (
    .match(smp.match),
    .sel(cfg.sel),
    .hit(hit)
  );

  assign final_hit = hit[cfg.last_level] ||
                     (|(smp.match & cfg.or_mask));
  // empty mask means no restart term at all
  assign rs_hit = |(smp.match & cfg.rs_mask);
  assign imm_final = cfg.imm[cfg.last_level];
  assign occ_plus = {1'b0, occ_cnt_reg} + 17'h00001;

  // one evaluation per valid sample
  always_comb begin
    level_next = level_reg;
    occ_cnt_next = occ_cnt_reg;
    trig_now = 1'b0;
    if (start_reg) begin
      level_next = 2'h0;
      occ_cnt_next = 16'h0000;
    end else if (smp.valid && armed_reg) begin
      if (rs_hit && (level_reg != 2'h0 || occ_cnt_reg != 16'h0000)) begin
        level_next = 2'h0;
        occ_cnt_next = 16'h0000;
      end else if (level_reg == cfg.last_level) begin
        if (final_hit) begin
          if (imm_final || occ_plus >= {1'b0, cfg.occ}) begin
            trig_now = 1'b1;
          end else begin
            occ_cnt_next = occ_plus[15:0];
          end
        end else if (imm_final) begin
          level_next = restart_level(hit[0]);
        end
      end else begin
        if (hit[level_reg]) begin
          level_next = level_reg + 2'h1;
        end else if (cfg.imm[level_reg]) begin
          level_next = restart_level(hit[0]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_reg <= 2'h0;
      occ_cnt_reg <= 16'h0000;
    end else begin
      level_reg <= level_next;
      occ_cnt_reg <= occ_cnt_next;
    end
  end

  // armed from run start until the trigger fires
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (start_reg) begin
      armed_reg <= 1'b1;
    end else if (trig_now) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trigger <= 1'b0;
    end else begin
      trigger <= trig_now;
    end
  end

  capture_ctl #(
    .MEM_DEPTH(MEM_DEPTH)
  ) u_cap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(start_reg),
    .sample_valid(smp.valid),
    .trig_now(trig_now),
    .pos(cfg.pos),
    .store_en(cap_store),
    .done(cap_done),
    .active(cap_active)
  );

  assign store_en = cap_store;
  assign acq_done = cap_done;

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        `ADDR_CTRL: rd_data <= {11'h000, last_reg, pos_reg, 1'b0};
        `ADDR_SEL: rd_data <= {4'h0, sel_reg};
        `ADDR_LINK: rd_data <= {12'h000, imm_reg[3:1], 1'b0};
        `ADDR_OR_MASK: rd_data <= {8'h00, or_mask_reg};
        `ADDR_RS_MASK: rd_data <= {8'h00, rs_mask_reg};
        `ADDR_OCC: rd_data <= occ_reg;
        `ADDR_STATUS: rd_data <= {11'h000, cap_done, cap_active,
                                  armed_reg, level_reg};
        `ADDR_OCC_CNT: rd_data <= occ_cnt_reg;
        default: rd_data <= 16'h0000;
      endcase
    end else begin
      rd_data <= 16'h0000;
    end
  end

endmodule // state_trigger_sequencer

// [verification/trig_seq_monitor.sv]
// port checker for the trigger sequencer
module trig_seq_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire trig_seq_pkg::sample_t smp,
  input wire logic trigger,
  input wire logic store_en,
  input wire logic acq_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_trig_once;
    trigger |=> !trigger [*3];
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("second trigger in one run");
  property p_trig_store;
    trigger |-> store_en;
  endproperty
  a_trig_store: assert property (p_trig_store)
    else $error("trigger state not stored");
  property p_trig_cause;
    trigger |-> $past(smp.valid);
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("trigger without a sample");
  property p_store_cause;
    store_en |-> $past(smp.valid);
  endproperty
  a_store_cause: assert property (p_store_cause)
    else $error("store without a sample");
  property p_done_hold;
    acq_done && !wr_en && !$past(wr_en) |=> acq_done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done dropped without a new run");
  property p_done_quiet;
    acq_done && $past(acq_done) |-> !store_en;
  endproperty
  a_done_quiet: assert property (p_done_quiet)
    else $error("store after acquisition stop");
  property p_done_no_trig;
    acq_done && $past(acq_done) |-> !trigger;
  endproperty
  a_done_no_trig: assert property (p_done_no_trig)
    else $error("trigger after acquisition stop");
  property p_start_quiet;
    wr_en && addr == 3'h0 && wr_data[0] && !smp.valid |=> !trigger [*2];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("trigger too soon after run start");
endmodule // trig_seq_monitor

bind state_trigger_sequencer trig_seq_monitor u_trig_seq_monitor (
  .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .smp(smp),
  .trigger(trigger), .store_en(store_en), .acq_done(acq_done));

// [verification/target_state_bus.sv]
// target state bus model: one captured sample per cycle
module target_state_bus (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] val,
  output trig_seq_pkg::sample_t smp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial smp = '0;
  // idle match lines show inverse of last value
  always @(posedge sys_clk) begin
    smp.valid <= go;
    smp.match <= go ? val : ~smp.match;
  end
endmodule // target_state_bus

// [verification/test_state_trigger_sequencer.sv]
// self-checking bench for the trigger sequencer
module test_state_trigger_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, nrst = 0, wr_en = 0, rd_en = 0, go = 0, cnt_clr = 0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [7:0] val = 8'h00;
  logic [15:0] rd_data;
  trig_seq_pkg::sample_t smp;
  logic trigger, store_en, acq_done;
  int failures = 0, checked = 0, trig_cnt = 0, st_cnt = 0;
  logic [15:0] rv [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1,
                          16'h0, 16'h0};

  state_trigger_sequencer #(.MEM_DEPTH(16'h0008)) u_state_trigger_sequencer (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .smp(smp),
    .trigger(trigger), .store_en(store_en), .acq_done(acq_done));
  target_state_bus u_target_state_bus (.sys_clk(sys_clk), .go(go),
    .val(val), .smp(smp));

  initial forever #25 sys_clk = ~sys_clk;
  // single owner of the event counters; unknown output counts as a pulse
  always @(posedge sys_clk) begin
    if (cnt_clr) begin
      trig_cnt <= 0;
      st_cnt <= 0;
    end else begin
      trig_cnt <= trig_cnt + (trigger !== 1'b0);
      st_cnt <= st_cnt + (store_en !== 1'b0);
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [2:0] a, input logic [15:0] exp);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
    @(posedge sys_clk);
  endtask
  task run(input logic [15:0] sel, lnk, orm, rsm, occ, ctl);
    wr(3'h1, sel);
    wr(3'h2, lnk);
    wr(3'h3, orm);
    wr(3'h4, rsm);
    wr(3'h5, occ);
    cnt_clr <= 1'b1;
    wr(3'h0, ctl);
    cnt_clr <= 1'b0;
  endtask
  // samples sent lowest byte first, then extra samples of 02, then a short idle
  task feed(input logic [63:0] ms, input int n, input int extra);
    for (int i = 0; i < n; i++) begin
      go <= 1'b1;
      val <= ms[8*i +: 8];
      @(posedge sys_clk);
    end
    val <= 8'h02;
    repeat (extra) @(posedge sys_clk);
    go <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task counts(input int t, input int s, input logic d);
    chk(16'(trig_cnt), 16'(t));
    chk(16'(st_cnt), 16'(s));
    chk({15'h0000, acq_done}, {15'h0000, d});
  endtask

  task t_reset;
    for (int i = 0; i < 8; i++) rd(3'(i), rv[i]);
  endtask
  task t_levels;
    run(16'h0688, 16'h000E, 16'h0, 16'h0, 16'h1, 16'h001D);
    feed(64'h080201, 3, 0);
    counts(0, 3, 1'b0);
    feed(64'h08040201, 4, 0);
    counts(1, 7, 1'b1);
    run(16'h0008, 16'h0, 16'h0, 16'h0, 16'h1, 16'h000D);
    feed(64'h04040102, 4, 0);
    counts(0, 4, 1'b0);
    feed(64'h02, 1, 0);
    counts(1, 5, 1'b1);
  endtask
  task t_occ;
    run(16'h0003, 16'h0, 16'h0010, 16'h0, 16'h0003, 16'h0005);
    rd(3'h7, 16'h0000);
    feed(64'h1008, 2, 0);
    rd(3'h7, 16'h0002);
    counts(0, 2, 1'b0);
    feed(64'h10, 1, 0);
    counts(1, 3, 1'b1);
    run(16'h0008, 16'h0002, 16'h0, 16'h0, 16'h0005, 16'h000D);
    rd(3'h7, 16'h0000);
    feed(64'h0201, 2, 0);
    counts(1, 2, 1'b1);
  endtask
  task t_restart;
    run(16'h0008, 16'h0, 16'h0, 16'h0014, 16'h1, 16'h000D);
    feed(64'h021001020401, 6, 0);
    counts(0, 6, 1'b0);
    feed(64'h0201, 2, 0);
    counts(1, 8, 1'b1);
  endtask
  task t_modes;
    run(16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0003);
    feed(64'h0102, 2, 520);
    counts(1, 514, 1'b1);
    run(16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0001);
    feed(64'h010202, 3, 10);
    counts(1, 8, 1'b1);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_levels();
    t_occ();
    t_restart();
    t_modes();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    final_report();
  end
endmodule // test_state_trigger_sequencer
